// ---- adcsc_pkg.sv ----
// Constants, register map and carrier types for the converter sequencer
// What this block does
// - Analog-enabled pin goes to converter; its other functions are switched off.
// - Pull-high on a pin is disconnected while it is an analog input.
// - Analog enable overrides the port direction setting of the pin.
// - Source codes 000 and 100 convert the external channel picked by select.
// - Channel codes 0 to 11 pick pins 0 to 11; codes 11xx leave input floating.
// - Codes 001-011 pick supply /1 /2 /4; codes 101-111 pick reference /1 /2 /4.
// - Any internal source disconnects all external channels regardless of select.
// - Software pulses start high then low; one conversion follows the pulse.
// - Busy goes to one once a conversion has started and stays set.
// - Busy returns to zero when the conversion finishes.
// - Completion sets the request flag; with enable set an interrupt is raised.
// - Conversion clock is system clock divided by two to the select power.
// - Converter is powered only while the power enable bit is high.
// - Conversion is 4 sampling clocks then 12 converting clocks, 16 in all.
// - Conversion runs on its own without stalling the processor.
// - Result is a 12-bit unsigned code, full scale at the reference.
// - Result registers hold the new value by the time busy drops.
package adcsc_pkg;
  localparam int        RES_W       = 12;
  localparam int        NUM_CH      = 12;
  localparam int        DIV_W       = 7;
  localparam int        SAMPLE_CLKS = 4;
  localparam int        CONV_CLKS   = 12;
  // Register byte offsets
  localparam bit [7:0]  OFF_CTRL0   = 8'h00;
  localparam bit [7:0]  OFF_CTRL1   = 8'h04;
  localparam bit [7:0]  OFF_PIN_LO  = 8'h08;
  localparam bit [7:0]  OFF_PIN_HI  = 8'h0C;
  localparam bit [7:0]  OFF_RES_HI  = 8'h10;
  localparam bit [7:0]  OFF_RES_LO  = 8'h14;
  localparam bit [7:0]  OFF_IRQ     = 8'h18;
  // Field positions, first trial bit and floating channel code
  localparam int        CTL0_START  = 4;
  localparam int        CTL0_PWR    = 5;
  localparam int        CTL0_BUSY   = 7;
  localparam int        CTL1_SRC    = 5;
  localparam int        IRQ_FLAG    = 0;
  localparam int        IRQ_EN      = 1;
  localparam bit [11:0] SAR_MSB     = 12'h800;
  localparam bit [1:0]  CH_FLOAT    = 2'h3;

  typedef enum logic [1:0] {
    ADCSC_IDLE   = 2'b00,
    ADCSC_HOLD   = 2'b01,
    ADCSC_SAMPLE = 2'b10,
    ADCSC_CONV   = 2'b11
  } adcsc_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } adcsc_wb_req_t;

  typedef struct packed {
    adcsc_state_t st;
    logic [6:0]   div_cnt;
    logic [3:0]   cnt;
    logic [11:0]  sar;
    logic [11:0]  mask;
    logic [11:0]  result;
    logic [3:0]   ch_sel;
    logic [2:0]   src;
    logic [2:0]   cks;
    logic         start;
    logic         pwr;
    logic [11:0]  pin_en;
    logic         irq_flag;
    logic         irq_en;
    logic         ack;
    logic [31:0]  dat;
  } adcsc_regs_t;
endpackage

// ---- adcsc_top.sv ----
// Converter sequencer: pin override, input select, divider, SAR control
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module adcsc_top (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  adcsc_pkg::adcsc_wb_req_t     wb_i,
  output logic                         wb_ack_o,
  output logic [31:0]                  wb_dat_o,
  // Interrupt request
  output logic                         irq_o,
  // Port logic requests for the shared pins
  input  wire logic [11:0]             gpio_oe_i,
  input  wire logic [11:0]             gpio_pu_i,
  output logic [11:0]                  pin_oe_o,
  output logic [11:0]                  pin_pu_o,
  output logic [11:0]                  pin_analog_o,
  // Analog front end
  input  wire logic                    comp_i,
  output logic                         adc_pwr_o,
  output logic                         sample_o,
  output logic [11:0]                  dac_o,
  output logic [11:0]                  chan_sel_o,
  output logic [2:0]                   int_src_o
);
  import adcsc_pkg::*;

  adcsc_regs_t q;
  adcsc_regs_t n;
  logic        tick;
  logic        busy;
  logic        done;
  logic        wr;
  logic        ext;
  logic [6:0]  per_m1;
  logic [11:0] sar_d;
  logic [31:0] rd;
  logic [3:0]  htk;

  assign busy   = (q.st == ADCSC_SAMPLE) || (q.st == ADCSC_CONV);
  assign per_m1 = DIV_W'((8'h01 << q.cks) - 8'h01);
  assign tick   = (q.div_cnt == per_m1);
  // Gated by power so that an abort leaves no result and no request
  assign done   = (q.st == ADCSC_CONV) && tick && (q.mask == 12'h001)
                  && q.pwr;
  // keep trial bit only when input is at or above it
  assign sar_d  = comp_i ? q.sar : (q.sar & ~q.mask);
  // external source codes 000 and 100
  assign ext    = (q.src[1:0] == 2'h0);
  // Write lands on the acknowledging edge, as the master samples it there
  assign wr     = wb_i.cyc && wb_i.stb && wb_i.we && q.ack && wb_i.sel[0];

  always_comb begin
    rd = 32'h0000_0000;
    if (wb_i.adr == OFF_CTRL0) begin
      rd[3:0]        = q.ch_sel;
      rd[CTL0_START] = q.start;
      rd[CTL0_PWR]   = q.pwr;
      rd[CTL0_BUSY]  = busy;
    end else if (wb_i.adr == OFF_CTRL1) begin
      rd[2:0]              = q.cks;
      rd[CTL1_SRC +: 3]    = q.src;
    end else if (wb_i.adr == OFF_PIN_LO) begin
      rd[7:0] = q.pin_en[7:0];
    end else if (wb_i.adr == OFF_PIN_HI) begin
      rd[3:0] = q.pin_en[11:8];
    end else if (wb_i.adr == OFF_RES_HI) begin
      rd[3:0] = q.result[11:8];
    end else if (wb_i.adr == OFF_RES_LO) begin
      rd[7:0] = q.result[7:0];
    end else if (wb_i.adr == OFF_IRQ) begin
      rd[IRQ_FLAG] = q.irq_flag;
      rd[IRQ_EN]   = q.irq_en;
    end
  end

  always_comb begin
    n         = q;
    n.ack     = wb_i.cyc && wb_i.stb && !q.ack;
    if (wb_i.cyc && wb_i.stb && !q.ack) begin
      n.dat = rd;
    end
    // Lowering the divider select mid-count lets the counter wrap once
    n.div_cnt = tick ? 7'h00 : q.div_cnt + 7'h01;
    if (wr) begin
      if (wb_i.adr == OFF_CTRL0) begin
        n.ch_sel = wb_i.dat[3:0];
        n.start  = wb_i.dat[CTL0_START];
        n.pwr    = wb_i.dat[CTL0_PWR];
      end else if (wb_i.adr == OFF_CTRL1) begin
        n.cks = wb_i.dat[2:0];
        n.src = wb_i.dat[CTL1_SRC +: 3];
      end else if (wb_i.adr == OFF_PIN_LO) begin
        n.pin_en[7:0] = wb_i.dat[7:0];
      end else if (wb_i.adr == OFF_PIN_HI) begin
        n.pin_en[11:8] = wb_i.dat[3:0];
      end else if (wb_i.adr == OFF_IRQ) begin
        n.irq_en = wb_i.dat[IRQ_EN];
        if (wb_i.dat[IRQ_FLAG]) begin
          n.irq_flag = 1'b0;
        end
      end
    end
    case (q.st)
      ADCSC_IDLE: begin
        if (q.start && q.pwr) begin
          n.st = ADCSC_HOLD;
        end
      end
      ADCSC_HOLD: begin
        // falling start edge launches one conversion
        if (!q.start) begin
          n.st      = ADCSC_SAMPLE;
          n.div_cnt = 7'h00;
          n.cnt     = 4'h0;
        end
      end
      ADCSC_SAMPLE: begin
        if (tick) begin
          n.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'(SAMPLE_CLKS - 1)) begin
            n.st   = ADCSC_CONV;
            n.cnt  = 4'h0;
            n.sar  = SAR_MSB;
            n.mask = SAR_MSB;
          end
        end
      end
      ADCSC_CONV: begin
        // runs alone, the bus stays free meanwhile
        // one result bit per conversion clock
        if (tick) begin
          n.sar  = sar_d | (q.mask >> 1);
          n.mask = q.mask >> 1;
          if (done) begin
            n.result = sar_d;
            n.st     = ADCSC_IDLE;
          end
        end
      end
      default: begin
        n.st = ADCSC_IDLE;
      end
    endcase
    // start held high keeps the sequencer reset
    if (q.start && q.pwr && busy) begin
      n.st = ADCSC_HOLD;
    end
    if (!q.pwr) begin
      n.st = ADCSC_IDLE;
    end
    // completion sets request; set beats a clear
    if (done) begin
      n.irq_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q    <= '0;
      q.st <= ADCSC_IDLE;
    end else begin
      q <= n;
    end
  end

  // Tick count of the running conversion, for checking only
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy) begin
      htk <= 4'h0;
    end else if (tick) begin
      htk <= htk + 4'h1;
    end
  end

  assign wb_ack_o     = q.ack;
  assign wb_dat_o     = q.dat;
  assign irq_o        = q.irq_flag && q.irq_en;
  // analog power follows the enable bit
  assign adc_pwr_o    = q.pwr;
  assign sample_o     = (q.st == ADCSC_SAMPLE);
  assign dac_o        = q.sar;
  assign pin_analog_o = q.pin_en;
  assign pin_oe_o     = gpio_oe_i & ~q.pin_en;
  assign pin_pu_o     = gpio_pu_i & ~q.pin_en;

  // one-hot channel, none when floating or internal
  always_comb begin
    chan_sel_o = 12'h000;
    if (ext && (q.ch_sel[3:2] != CH_FLOAT)) begin
      chan_sel_o[q.ch_sel] = 1'b1;
    end
  end

  // internal source code, zero when external
  assign int_src_o = ext ? 3'h0 : q.src;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_busy_on_start: assert property (
    (q.st == ADCSC_HOLD) && !q.start && q.pwr |=> busy [*2])
    else $error("busy not raised after start pulse");

  a_conv_length: assert property (
    done |-> (htk == 4'(SAMPLE_CLKS + CONV_CLKS - 1)))
    else $error("conversion length not sixteen clocks");

  a_done_effects: assert property (
    done |=> !busy && q.irq_flag && (q.result == $past(sar_d)))
    else $error("completion did not clear busy or store result");

  a_unpowered_idle: assert property (
    !q.pwr |=> !busy && $stable(q.result))
    else $error("activity while converter unpowered");

  a_start_held: assert property (
    q.start && q.pwr |=> !busy)
    else $error("sequencer ran while start held high");

  a_irq_gate: assert property (
    irq_o |-> q.irq_en && $past(done || q.irq_flag))
    else $error("interrupt without request or enable");

  a_pin_override: assert property (
    ((pin_oe_o | pin_pu_o) & pin_analog_o) == 12'h000)
    else $error("analog pin still driven or pulled");

  a_internal_off: assert property (
    (q.src[1:0] != 2'h0) || (q.ch_sel[3:2] == CH_FLOAT)
      |-> chan_sel_o == 12'h000 ##1 $past(int_src_o) == $past(q.src)
        || $past(q.src[1:0]) == 2'h0)
    else $error("external channel left on");

  a_sample_phase: assert property (
    $rose(sample_o) && q.cks == 3'h0 |-> sample_o [*4] ##1 !sample_o)
    else $error("sampling phase not four clocks");

  a_sample_first: assert property (
    (q.st == ADCSC_HOLD) && !q.start && q.pwr |=> sample_o)
    else $error("sampling did not follow start pulse");

  a_sample_to_conv: assert property (
    (q.st == ADCSC_SAMPLE) && tick && (q.cnt == 4'h3) && q.pwr && !q.start
      |=> (q.st == ADCSC_CONV) && (dac_o == SAR_MSB))
    else $error("conversion phase did not open with top trial bit");

  a_trial_shift: assert property (
    (q.st == ADCSC_CONV) && tick && !done && q.pwr && !q.start
      |=> q.mask == ($past(q.mask) >> 1))
    else $error("trial bit did not move down one place");

  a_mask_live: assert property (
    (q.st == ADCSC_CONV) |-> (q.mask != 12'h000))
    else $error("conversion state without a trial bit");

  a_tick_period: assert property (
    tick && (q.cks != 3'h0) && !wr |=> !tick)
    else $error("divided clock ticked twice in a row");

  a_done_powered: assert property (
    done |-> q.pwr)
    else $error("completion while converter unpowered");

  a_unpowered_flag: assert property (
    !q.pwr && !q.irq_flag |=> !q.irq_flag)
    else $error("request raised while converter unpowered");

  a_flag_clear: assert property (
    wr && (wb_i.adr == OFF_IRQ) && wb_i.dat[IRQ_FLAG] && !done
      |=> !q.irq_flag)
    else $error("request flag not cleared by write");

  a_runs_alone: assert property (
    busy && !q.start && q.pwr && !done |=> busy)
    else $error("conversion stopped on its own");

  a_result_hold: assert property (
    !done |=> $stable(q.result))
    else $error("result changed without completion");

  a_chan_onehot: assert property (
    $onehot0(chan_sel_o))
    else $error("more than one external channel selected");

  a_int_src_code: assert property (
    !ext |-> (int_src_o[1:0] != 2'h0))
    else $error("internal source shown as external code");

  // Bus answers: one acknowledge per access, never unasked
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  a_ack_follows: assert property (
    wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  a_ack_needs_req: assert property (
    !(wb_i.cyc && wb_i.stb) |=> !wb_ack_o)
    else $error("acknowledge without request");
endmodule // adcsc_top

// ---- adcsc_top_tb.sv ----
// Self-checking bench for the converter sequencer over its register bus
`timescale 1ns/1ps
module adcsc_top_tb;
  import adcsc_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  adcsc_wb_req_t wb    = '0;
  logic          wb_ack_o;
  logic [31:0]   wb_dat_o;
  logic          irq_o;
  logic [11:0]   gpio_oe_i = 12'hFFF;
  logic [11:0]   gpio_pu_i = 12'hFFF;
  logic [11:0]   pin_oe_o, pin_pu_o, pin_analog_o, dac_o, chan_sel_o;
  logic          comp_i = 1'b0;
  logic          adc_pwr_o, sample_o;
  logic [2:0]    int_src_o;
  int            n_errors = 0;
  int            n_tests = 0;
  int            cyc_cnt = 0, t0 = 0, t1 = 0, n_samp = 0;
  logic          samp_q = 1'b0, irq_q = 1'b0;
  logic [31:0]   rd;

  adcsc_top adcsc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o),
    .gpio_oe_i(gpio_oe_i), .gpio_pu_i(gpio_pu_i), .pin_oe_o(pin_oe_o),
    .pin_pu_o(pin_pu_o), .pin_analog_o(pin_analog_o), .comp_i(comp_i),
    .adc_pwr_o(adc_pwr_o), .sample_o(sample_o), .dac_o(dac_o),
    .chan_sel_o(chan_sel_o), .int_src_o(int_src_o));

  always #12.5 clk_i = ~clk_i;

  // Edge stamps of sampling start and request rise, seen before updates land
  always @(posedge clk_i) begin
    if (sample_o === 1'b1 && !samp_q) t0 = cyc_cnt;
    if (irq_o === 1'b1 && !irq_q) t1 = cyc_cnt;
    if (sample_o === 1'b1) n_samp++;
    samp_q = (sample_o === 1'b1);
    irq_q = (irq_o === 1'b1);
    cyc_cnt++;
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the answer is awaited under a bound
  task automatic wb_xfer(logic we, logic [7:0] adr, logic [31:0] d,
                         output logic [31:0] q);
    int i;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb <= '0;
    if (i == 20) begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask

  task automatic wr(logic [7:0] adr, logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, adr, d, q);
  endtask

  task automatic conv(logic [2:0] cks, logic cmp, logic [11:0] exp);
    int i;
    comp_i <= cmp;
    wr(OFF_CTRL1, {24'h0, 5'h00, cks});
    wr(OFF_CTRL0, 32'h20);
    repeat (10) @(posedge clk_i);
    wr(OFF_CTRL0, 32'h30);
    n_samp = 0;
    wr(OFF_CTRL0, 32'h20);
    for (i = 0; i < 5000 && irq_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 5000) begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge clk_i);
    chk("conversion length", 32'(16 << cks), 32'(t1 - t0));
    chk("sampling length", 32'(4 << cks), 32'(n_samp));
    wb_xfer(1'b0, OFF_CTRL0, '0, rd);
    chk("busy after end", 32'h0, 32'(rd[CTL0_BUSY]));
    chk("trial code", 32'(exp), 32'(dac_o));
    wb_xfer(1'b0, OFF_RES_HI, '0, rd);
    chk("result high", 32'(exp[11:8]), rd);
    wb_xfer(1'b0, OFF_RES_LO, '0, rd);
    chk("result low", 32'(exp[7:0]), rd);
    wr(OFF_IRQ, 32'h3);
    chk("request cleared", 32'h0, 32'(irq_o));
  endtask

  initial begin
    int s, c, k;
    logic [3:0] chl [3] = '{4'h3, 4'hB, 4'hC};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset channel", 32'h001, 32'(chan_sel_o));
    wr(OFF_PIN_LO, 32'hA5);
    wr(OFF_PIN_HI, 32'hF9);
    chk("analog pins", 32'h9A5, 32'(pin_analog_o));
    chk("pull-high masked", 32'h65A, 32'(pin_pu_o));
    chk("direction masked", 32'h65A, 32'(pin_oe_o));
    wb_xfer(1'b0, OFF_PIN_HI, '0, rd);
    chk("pin high readback", 32'h9, rd);
    wb_xfer(1'b0, 8'h40, '0, rd);
    chk("unmapped read", 32'h0, rd);
    for (s = 0; s < 8; s++) begin
      for (k = 0; k < 3; k++) begin
        c = chl[k];
        wr(OFF_CTRL1, 32'(s << CTL1_SRC));
        wr(OFF_CTRL0, 32'(c));
        chk("channel one-hot", (s % 4 == 0 && c < 12) ? 32'(1 << c) : 32'h0,
            32'(chan_sel_o));
        chk("internal source", (s % 4 == 0) ? 32'h0 : 32'(s),
            32'(int_src_o));
      end
    end
    wr(OFF_IRQ, 32'h2);
    n_samp = 0;
    wr(OFF_CTRL0, 32'h10);
    wr(OFF_CTRL0, 32'h00);
    repeat (40) @(posedge clk_i);
    chk("start ignored unpowered", 32'h0, 32'(n_samp | irq_o));
    chk("power off", 32'h0, 32'(adc_pwr_o));
    conv(3'h0, 1'b0, 12'h000);
    conv(3'h1, 1'b1, 12'hFFF);
    conv(3'h2, 1'b1, 12'hFFF);
    conv(3'h5, 1'b0, 12'h000);
    wr(OFF_CTRL0, 32'h0);
    chk("power released", 32'h0, 32'(adc_pwr_o));
    tally_and_finish();
  end
endmodule // adcsc_top_tb
